// file: adc_serial_ctl.sv
// serial control and conversion sequencing of a 10-bit successive-approximation converter
`timescale 1ns/1ns
`include "adc_ctl_defs.svh"

// Overview of operation
// (RQ1) chip select falling clears counters and control, then enables input, output and clock.
// (RQ2) chip select rising disables serial input, serial output and serial clock.
// (RQ3) start input falling begins sampling; its low time sets the sampling length.
// (RQ4) start input rising puts sample-and-hold into hold and launches conversion.
// (RQ5) start input ignores serial clock and works while chip select is high.
// (RQ6) a 4-bit serial command picks channel, test voltage, rate or power-down.
// (RQ7) microprocessor mode: command MSB first on first four rising edges, falling if inverted.
// (RQ8) DSP mode: command MSB first on first four falling edges, rising if inverted.
// (RQ9) after four command bits the serial input is ignored for the conversion period.
// (RQ10) serial output floats while chip select is high, driven when low or after frame sync.
// (RQ11) output first drives the leading bit of the previous result, then the rest.
// (RQ12) output changes on falling edges in microprocessor mode, rising edges in DSP mode.
// (RQ13) end-of-conversion drops on tenth launch edge and stays low until result ready.
// (RQ14) in DSP mode the host marks each frame start with frame sync.
// (RQ15) with a microprocessor port the host holds frame sync high.
// (RQ16) polarity select low inverts command capture edges in both modes.
// (RQ17) polarity select also offers a way into a built-in test mode.
// (RQ18) high-impedance sources should use the start input for longer sampling.
// (RQ19) interface mode latched at chip select falling: frame sync high means microprocessor.
// (RQ20) host gives 10 to 16 clocks: four load command, six time sampling.
// (RQ21) microprocessor sampling runs fourth falling to tenth rising edge unless extended.
// (RQ22) on completion the result is loaded for the next access, then end-of-conversion rises.
module adc_serial_ctl #(
  parameter int RES_W = `ADC_RES_BITS,
  parameter int CMD_W = `ADC_CMD_BITS,
  parameter int CONV_CYCLES = `ADC_CONV_TIME_NS / `ADC_CLK_PERIOD_NS,
  parameter bit LSB_FIRST = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic io_clk,
  input wire logic cs_n,
  input wire logic data_in,
  output logic data_out,
  output logic data_out_oe_n,
  input wire logic frame_sync,
  input wire logic clock_polarity_sel,
  input wire logic async_conv_start_n,
  input wire logic [RES_W-1:0] sar_data,
  output logic eoc,
  output logic sample_en,
  output logic conv_start,
  output logic [CMD_W-1:0] command,
  output logic command_strobe,
  output logic test_mode,
  output adc_ctl_pkg::conv_state_t conv_state
);
  import adc_ctl_pkg::*;

  localparam logic [`ADC_CNT_BITS-1:0] CMD_LAST = `ADC_CNT_BITS'(`ADC_CMD_LAST_IDX);
  localparam logic [`ADC_CNT_BITS-1:0] LAUNCH_IDX = `ADC_CNT_BITS'(`ADC_LAUNCH_IDX);
  localparam logic [`ADC_CNT_BITS-1:0] MAX_EDGES = `ADC_CNT_BITS'(`ADC_MAX_EDGES);
  localparam logic [`ADC_CNT_BITS-1:0] RES_LAST = `ADC_CNT_BITS'(RES_W - 1);

  // ****************************************
  // link side, clocked by the host serial clock
  // ****************************************
  logic link_rst, if_mode, armed, link_active, cap_on_rise;
  logic [1:0] link_rst_pipe;
  logic [`ADC_CNT_BITS-1:0] rise_cnt, fall_cnt;
  logic [CMD_W-1:0] cmd_r, cmd_f, cmd_link;
  logic tog_lr, tog_lf, tog_sr, tog_sf;
  logic [`ADC_CNT_BITS-1:0] out_idx;
  logic [RES_W-1:0] result;

  // reset reaches the link side at once and leaves on the second rising serial clock edge, so no idle clock is needed
  always_ff @(posedge io_clk or posedge reset) begin
    if (reset) link_rst_pipe <= 2'b11;
    else link_rst_pipe <= {link_rst_pipe[0], 1'b0};
  end
  assign link_rst = link_rst_pipe[1];

  // mode is caught by the select edge itself, so it is valid before any serial clock
  always_ff @(negedge cs_n) begin
    if_mode <= frame_sync; // [RQ19] [RQ15]
  end

  assign link_active = if_mode | armed;
  assign cap_on_rise = (if_mode == clock_polarity_sel); // [RQ16]
  assign cmd_link = cap_on_rise ? cmd_r : cmd_f;

  // deselect clears the frame state, so a fresh select always starts from zero
  always_ff @(posedge io_clk or posedge cs_n) begin
    if (cs_n) begin
      armed <= 1'b0; // [RQ1] [RQ2]
    end else if (!if_mode && !frame_sync) begin
      armed <= 1'b1; // [RQ14]
    end
  end

  always_ff @(posedge io_clk or posedge cs_n) begin
    if (cs_n) begin
      rise_cnt <= '0; // [RQ1]
    end else if (link_active && rise_cnt != MAX_EDGES) begin
      rise_cnt <= rise_cnt + 1'b1;
    end
  end

  // command shifters survive deselect: the system side may take the word after the frame has ended
  always_ff @(posedge io_clk) begin
    if (!cs_n && link_active && cap_on_rise && rise_cnt <= CMD_LAST)
      cmd_r <= {cmd_r[CMD_W-2:0], data_in}; // [RQ7] [RQ8] [RQ9]
  end

  always_ff @(negedge io_clk or posedge cs_n) begin
    if (cs_n) begin
      fall_cnt <= '0; // [RQ1]
    end else if (link_active && fall_cnt != MAX_EDGES) begin
      fall_cnt <= fall_cnt + 1'b1;
    end
  end

  always_ff @(negedge io_clk) begin
    if (!cs_n && link_active && !cap_on_rise && fall_cnt <= CMD_LAST)
      cmd_f <= {cmd_f[CMD_W-2:0], data_in}; // [RQ7] [RQ8] [RQ9]
  end

  // event toggles survive deselect so the system side never misses one
  always_ff @(posedge io_clk or posedge link_rst) begin
    if (link_rst) begin
      tog_lr <= 1'b0;
      tog_sr <= 1'b0;
    end else if (!cs_n && link_active) begin
      if (if_mode && rise_cnt == LAUNCH_IDX) begin
        tog_lr <= ~tog_lr; // [RQ13] [RQ21]
      end
      if (!if_mode && rise_cnt == CMD_LAST) begin
        tog_sr <= ~tog_sr; // [RQ20]
      end
    end
  end

  always_ff @(negedge io_clk or posedge link_rst) begin
    if (link_rst) begin
      tog_lf <= 1'b0;
      tog_sf <= 1'b0;
    end else if (!cs_n && link_active) begin
      if (!if_mode && fall_cnt == LAUNCH_IDX) begin
        tog_lf <= ~tog_lf; // [RQ13]
      end
      if (if_mode && fall_cnt == CMD_LAST) begin
        tog_sf <= ~tog_sf; // [RQ21]
      end
    end
  end

  // output index counts change edges; result reloads whenever a conversion ends, even while a host is reading it
  assign out_idx = if_mode ? fall_cnt : rise_cnt; // [RQ12]
  always_comb begin
    data_out = 1'b0;
    if (out_idx <= RES_LAST) begin
      data_out = LSB_FIRST ? result[out_idx[3:0]] : result[RES_LAST[3:0] - out_idx[3:0]]; // [RQ11]
    end
  end
  assign data_out_oe_n = cs_n | (!if_mode && frame_sync && !armed); // [RQ10] [RQ2]

  // ****************************************
  // system side: crossings and conversion sequencer
  // ****************************************
  logic [3:0] tog_q, tog_prev;
  logic [2:0] pin_q;
  logic async_conv_start_n_prev, launch_ev, sample_ev, async_conv_start_n_fall, async_conv_start_n_rise, async_conv_start_n_low, launch_pending, eoc_reg, done;
  logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt;
  conv_state_t state;

  sync_stage #(.WIDTH(4)) u_tog_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .d({tog_lr, tog_lf, tog_sr, tog_sf}),
    .q(tog_q)
  );

  sync_stage #(.WIDTH(3)) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .d(~{async_conv_start_n, cs_n, clock_polarity_sel}), // inverted so reset gives the idle pin levels
    .q(pin_q)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      tog_prev <= '0;
      async_conv_start_n_prev <= 1'b0;
    end else if (ce) begin
      tog_prev <= tog_q;
      async_conv_start_n_prev <= pin_q[2];
    end
  end

  assign async_conv_start_n_low = pin_q[2];
  assign async_conv_start_n_fall = !async_conv_start_n_prev && pin_q[2]; // [RQ5]
  assign async_conv_start_n_rise = async_conv_start_n_prev && !pin_q[2]; // [RQ5]
  assign launch_ev = (tog_q[`ADC_TOG_LAUNCH_R] ^ tog_prev[`ADC_TOG_LAUNCH_R])
    | (tog_q[`ADC_TOG_LAUNCH_F] ^ tog_prev[`ADC_TOG_LAUNCH_F]);
  assign sample_ev = (tog_q[`ADC_TOG_SAMPLE_R] ^ tog_prev[`ADC_TOG_SAMPLE_R])
    | (tog_q[`ADC_TOG_SAMPLE_F] ^ tog_prev[`ADC_TOG_SAMPLE_F]);
  // covers the crossing delay so the flag drops at the launch edge itself
  assign launch_pending = (tog_lr ^ tog_lf) ^ (tog_prev[`ADC_TOG_LAUNCH_R] ^ tog_prev[`ADC_TOG_LAUNCH_F]);
  assign eoc = eoc_reg & ~launch_pending; // [RQ13]

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= st_idle;
      conv_cnt <= '0;
      done <= 1'b0;
      conv_start <= 1'b0;
      command <= '0;
      command_strobe <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      conv_start <= 1'b0;
      command_strobe <= 1'b0;
      case (state)
        st_idle, st_sample: begin
          if (async_conv_start_n_rise) begin
            state <= st_convert; // [RQ4]
            conv_start <= 1'b1;
            conv_cnt <= '0;
          end else if (launch_ev && !async_conv_start_n_low) begin
            state <= st_convert; // [RQ13] [RQ21]
            conv_start <= 1'b1;
            conv_cnt <= '0;
            command <= cmd_link; // [RQ6]
            command_strobe <= 1'b1;
          end else if (async_conv_start_n_fall || sample_ev) begin
            state <= st_sample; // [RQ3] [RQ21] [RQ18]
          end
        end
        st_convert: begin
          if (conv_cnt == ($bits(conv_cnt))'(CONV_CYCLES - 1)) begin
            state <= st_idle;
            done <= 1'b1;
          end else begin
            conv_cnt <= conv_cnt + 1'b1;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // result lands one cycle before the flag rises, so a host never reads a half word
  always_ff @(posedge clk) begin
    if (reset) begin
      result <= '0;
      eoc_reg <= 1'b1;
    end else if (ce) begin
      if (state == st_convert && conv_cnt == ($bits(conv_cnt))'(CONV_CYCLES - 1)) begin
        result <= sar_data; // [RQ22]
      end
      if (state != st_convert && (async_conv_start_n_rise || (launch_ev && !async_conv_start_n_low))) begin
        eoc_reg <= 1'b0; // [RQ13]
      end else if (done) begin
        eoc_reg <= 1'b1; // [RQ22]
      end
    end
  end

  // test entry: polarity select held low while deselected and start held low
  always_ff @(posedge clk) begin
    if (reset) begin
      test_mode <= 1'b0;
    end else if (ce) begin
      test_mode <= !pin_q[1] && pin_q[0] && async_conv_start_n_low; // [RQ17]
    end
  end

  assign sample_en = (state == st_sample) || (state == st_idle && async_conv_start_n_low);
  assign conv_state = state;

  // ****************************************
  // assertions
  // ****************************************
  property p_launch_drop;
    @(posedge clk) disable iff (reset)
      (ce && state != st_convert && launch_ev && !async_conv_start_n_low && !async_conv_start_n_rise) |=> (!eoc_reg && state == st_convert);
  endproperty
  a_launch_drop: assert property (p_launch_drop) else $error("launch did not start conversion"); // [RQ13]

  property p_busy_low;
    @(posedge clk) disable iff (reset) (state == st_convert) |-> !eoc;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("eoc high during conversion"); // [RQ13]

  property p_done_load;
    @(posedge clk) disable iff (reset)
      (ce && state == st_convert && conv_cnt == ($bits(conv_cnt))'(CONV_CYCLES - 1))
      |=> (result == $past(sar_data) && !eoc_reg) ##1 (eoc_reg || !ce);
  endproperty
  a_done_load: assert property (p_done_load) else $error("result or eoc order wrong"); // [RQ22]

  property p_async_conv_start_n_hold;
    @(posedge clk) disable iff (reset) (ce && async_conv_start_n_rise && state != st_convert) |=> state == st_convert;
  endproperty
  a_async_conv_start_n_hold: assert property (p_async_conv_start_n_hold) else $error("start rise did not hold"); // [RQ4]

  property p_async_conv_start_n_sample;
    @(posedge clk) disable iff (reset)
      (ce && async_conv_start_n_fall && state == st_idle && !launch_ev) |=> (state == st_sample && sample_en);
  endproperty
  a_async_conv_start_n_sample: assert property (p_async_conv_start_n_sample) else $error("start fall did not sample"); // [RQ3]

  property p_float_deselect;
    @(posedge clk) disable iff (reset) cs_n |-> data_out_oe_n;
  endproperty
  a_float_deselect: assert property (p_float_deselect) else $error("output driven while deselected"); // [RQ10]

  property p_cmd_ignore;
    @(posedge io_clk) disable iff (link_rst || cs_n) (rise_cnt > CMD_LAST) |=> $stable(cmd_r);
  endproperty
  a_cmd_ignore: assert property (p_cmd_ignore) else $error("command changed after four bits"); // [RQ9]

  property p_cmd_shift;
    @(posedge io_clk) disable iff (link_rst || cs_n)
      (cap_on_rise && link_active && rise_cnt <= CMD_LAST) |=> cmd_r[0] == $past(data_in);
  endproperty
  a_cmd_shift: assert property (p_cmd_shift) else $error("command bit not captured"); // [RQ7]

  property p_mp_out_stable;
    @(posedge io_clk) disable iff (link_rst || cs_n) if_mode |-> fall_cnt == rise_cnt;
  endproperty
  a_mp_out_stable: assert property (p_mp_out_stable) else $error("output moved on rising edge"); // [RQ12]

  c_link_launch: cover property (@(posedge clk) disable iff (reset) launch_ev && !async_conv_start_n_low ##1 state == st_convert);
  c_ext_sample: cover property (@(posedge clk) disable iff (reset) async_conv_start_n_fall ##[1:400] async_conv_start_n_rise);
  c_dsp_frame: cover property (@(posedge io_clk) disable iff (link_rst || cs_n) !if_mode && armed);
  c_done: cover property (@(posedge clk) disable iff (reset) done);
endmodule // adc_serial_ctl

// file: adc_ctl_defs.svh
// timing counts, widths and edge numbers for the converter serial control block
`ifndef ADC_CTL_DEFS_SVH
`define ADC_CTL_DEFS_SVH

`define ADC_CLK_PERIOD_NS 50
`define ADC_CONV_TIME_NS 10000
`define ADC_RES_BITS 10
`define ADC_CMD_BITS 4
`define ADC_CMD_LAST_IDX 3
`define ADC_LAUNCH_IDX 9
`define ADC_MAX_EDGES 16
`define ADC_CNT_BITS 5
`define ADC_TOG_LAUNCH_R 3
`define ADC_TOG_LAUNCH_F 2
`define ADC_TOG_SAMPLE_R 1
`define ADC_TOG_SAMPLE_F 0

`endif

// file: adc_ctl_pkg.sv
// types shared by the converter serial control block
package adc_ctl_pkg;

  typedef enum logic [2:0] {
    st_idle    = 3'b001,
    st_sample  = 3'b010,
    st_convert = 3'b100
  } conv_state_t;

endpackage

// file: sync_stage.sv
// two flip-flop synchroniser for independent single-bit levels or toggles
`timescale 1ns/1ns
module sync_stage #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sync_stage

// file: host_port_model.sv
// host serial port model for the converter link
`timescale 1ns/1ns
module host_port_model (
  output logic io_clk,
  output logic cs_n,
  output logic data_in,
  output logic frame_sync,
  input wire logic data_out,
  input wire logic data_out_oe_n,
  input wire logic eoc
);
  localparam int HALF = 80;
  initial begin
    io_clk = 1'b0;
    cs_n = 1'b1;
    data_in = 1'b0;
    frame_sync = 1'b1;
  end
  // a few edges inside reset; clock is idle otherwise
  task automatic reset_clock();
    repeat (4) begin
      #HALF;
      io_clk = ~io_clk;
    end
  endtask
  // ****
  // one access: mp=1 microprocessor frame, else frame-synced
  // ****
  task automatic access(input logic mp, input logic [3:0] cmd, input int n,
                        output logic [9:0] word, output logic oe_seen, output logic eoc_seen);
    word = '0;
    eoc_seen = 1'bx;
    frame_sync = mp;
    #37;
    cs_n = 1'b0;
    #HALF;
    if (!mp) begin
      io_clk = 1'b1; // rising edge with sync low opens the frame
      #HALF;
    end
    oe_seen = data_out_oe_n;
    for (int k = 1; k <= n; k++) begin // 10 to 16 clocks
      data_in = (k <= 4) ? cmd[4-k] : ~data_in; // msb first, then noise
      #(HALF/2);
      if (k <= 10) word[10-k] = data_out;
      io_clk = ~io_clk;
      #(HALF/2);
      if (k == 10) eoc_seen = eoc;
      io_clk = ~io_clk;
      #HALF;
    end
    cs_n = 1'b1;
    data_in = ~data_in;
    #(HALF/2);
    io_clk = 1'b0;
    frame_sync = 1'b1;
  endtask
endmodule // host_port_model

// file: adc_serial_ctl_bench.sv
// self-checking bench for the converter serial control block
`timescale 1ns/1ns
module adc_serial_ctl_bench;
  import adc_ctl_pkg::*;
  localparam int CONV = 8;
  logic clk, reset, io_clk, cs_n, data_in, data_out, data_out_oe_n, frame_sync;
  logic clock_polarity_sel, async_conv_start_n, eoc, sample_en, conv_start, command_strobe, test_mode, ce;
  logic [9:0] sar_data;
  logic [3:0] command;
  conv_state_t conv_state;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int launches = 0;
  int seed = 41;
  logic [3:0] cmd_q[$];

  adc_serial_ctl #(.CONV_CYCLES(CONV)) u_dut (
    .clk(clk), .reset(reset), .ce(ce), .io_clk(io_clk), .cs_n(cs_n), .data_in(data_in),
    .data_out(data_out), .data_out_oe_n(data_out_oe_n), .frame_sync(frame_sync),
    .clock_polarity_sel(clock_polarity_sel), .async_conv_start_n(async_conv_start_n),
    .sar_data(sar_data), .eoc(eoc), .sample_en(sample_en), .conv_start(conv_start),
    .command(command), .command_strobe(command_strobe), .test_mode(test_mode), .conv_state(conv_state)
  );
  host_port_model u_host (
    .io_clk(io_clk), .cs_n(cs_n), .data_in(data_in), .frame_sync(frame_sync),
    .data_out(data_out), .data_out_oe_n(data_out_oe_n), .eoc(eoc)
  );

  always #25 clk = ~clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // launch takes a few cycles to cross, then the conversion runs CONV cycles
  task automatic wait_eoc();
    int i;
    i = 0;
    while (eoc !== 1'b1 && i < 20) begin
      @(posedge clk);
      i++;
    end
    #2;
    check("ready in time", i < 20, 1'b1);
    check("launch seen", launches, 0);
    check("command delivered", cmd_q.size(), 0);
  endtask

  // ****
  // watchers: each command strobe takes the oldest note
  // ****
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      print_verdict();
    end
    if (command_strobe === 1'b1) begin
      if (cmd_q.size() == 0) check("spare strobe", 1'b1, 1'b0);
      else check("command", command, cmd_q.pop_front());
    end
    if (conv_start === 1'b1) begin
      check("launch noted", launches > 0, 1'b1);
      check("busy at launch", eoc, 1'b0);
      launches--;
    end
  end

  // ****
  // main sequence
  // ****
  initial begin
    logic [9:0] word, prev;
    logic oe_seen, eoc_seen;
    clk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    clock_polarity_sel = 1'b1;
    async_conv_start_n = 1'b1;
    sar_data = '0;
    prev = '0;
    fork
      u_host.reset_clock();
    join_none
    step(6);
    reset = 1'b0;
    step(3);
    check("idle ready", eoc, 1'b1);
    check("idle state", conv_state, st_idle);
    check("floats while deselected", data_out_oe_n, 1'b1);
    $display("reset test done");
    // all sixteen commands across both modes and both polarities, 10 to 16 clocks
    for (int i = 0; i < 16; i++) begin
      sar_data = 10'($random(seed));
      clock_polarity_sel = i[0];
      cmd_q.push_back(i[3:0]);
      launches++;
      u_host.access(i[1], i[3:0], 10 + i % 7, word, oe_seen, eoc_seen);
      check("previous result", word, prev);
      check("driven in frame", oe_seen, 1'b0);
      check("busy from tenth edge", eoc_seen, 1'b0);
      check("floats after frame", data_out_oe_n, 1'b1);
      wait_eoc();
      prev = sar_data;
      $display("access test %0d done", i);
    end
    // extended sampling with the link deselected
    sar_data = 10'($random(seed));
    async_conv_start_n = 1'b0;
    clock_polarity_sel = 1'b0;
    step(4);
    check("sampling on start low", conv_state, st_sample);
    check("sample enable", sample_en, 1'b1);
    check("test mode", test_mode, 1'b1);
    clock_polarity_sel = 1'b1;
    step(6);
    check("held in sampling", conv_state, st_sample);
    ce = 1'b0;
    launches++;
    async_conv_start_n = 1'b1; // long start pulse suits a slow source
    step(6);
    check("frozen by enable", conv_state, st_sample);
    check("ready while frozen", eoc, 1'b1);
    ce = 1'b1;
    step(4);
    check("busy after start rise", eoc, 1'b0);
    wait_eoc();
    check("back to idle", conv_state, st_idle);
    cmd_q.push_back(4'h5);
    launches++;
    u_host.access(1'b1, 4'h5, 10, word, oe_seen, eoc_seen);
    check("extended result", word, sar_data);
    wait_eoc();
    $display("extended sampling test done");
    print_verdict();
  end
endmodule // adc_serial_ctl_bench
